// >>> hw/sdcf_params.svh
`ifndef SDCF_PARAMS_SVH
`define SDCF_PARAMS_SVH

// Clock and timing
`define SDCF_CLK_HZ 125000000
`define SDCF_IDLE_TIME_MS 1000
`define SDCF_IDLE_CYCLES ((`SDCF_CLK_HZ / 1000) * `SDCF_IDLE_TIME_MS)
`define SDCF_FRAME_TIME_MS 3000
`define SDCF_FRAME_CYCLES ((`SDCF_CLK_HZ / 1000) * `SDCF_FRAME_TIME_MS)
`define SDCF_FLASH_TIME_MS 250
`define SDCF_FLASH_CYCLES ((`SDCF_CLK_HZ / 1000) * `SDCF_FLASH_TIME_MS)

// Flash counts per fault
`define SDCF_FLASH_OC 3'd1
`define SDCF_FLASH_OV 3'd2
`define SDCF_FLASH_PH 3'd4

// Reduction factors in percent
`define SDCF_IDLE_PCT 8'd60
`define SDCF_HALF_PCT 8'd50
`define SDCF_FULL_PCT 8'd100

// Current codes in units of 0.1 A
`define SDCF_CUR_MIN 8'd5
`define SDCF_CUR_MAX 8'd56

// Resolution limits in microsteps per full step
`define SDCF_RES_MIN 10'd1
`define SDCF_RES_MAX 10'd512

`endif

// >>> hw/sdcf_pkg.sv
package sdcf_pkg;

    typedef enum logic [1:0] {
        SDCF_FLT_NONE = 2'b00,
        SDCF_FLT_OC = 2'b01,
        SDCF_FLT_OV = 2'b10,
        SDCF_FLT_PH = 2'b11
    } sdcf_fault_t;

    typedef enum logic [1:0] {
        SDCF_LED_GAP = 2'b00,
        SDCF_LED_ON = 2'b01,
        SDCF_LED_OFF = 2'b10,
        SDCF_LED_REST = 2'b11
    } sdcf_led_t;

endpackage

// >>> hw/sdcf_drive.sv
`timescale 1ns/10ps
`include "sdcf_params.svh"

module sdcf_drive #(
    parameter int unsigned POS_W = 32,
    parameter int unsigned IDLE_CYCLES = `SDCF_IDLE_CYCLES,
    parameter int unsigned FRAME_CYCLES = `SDCF_FRAME_CYCLES,
    parameter int unsigned FLASH_CYCLES = `SDCF_FLASH_CYCLES
) (
    input wire logic REF_CLK_I,
    input wire logic RST_I,
    input wire logic STEP_PULSE_INPUT_I,
    input wire logic ROTATION_SENSE_I,
    input wire logic DRIVE_PERMIT_INPUT_I,
    input wire logic [2:0] CURRENT_SELECT_I,
    input wire logic STANDSTILL_LEVEL_SELECT_I,
    input wire logic [3:0] RESOLUTION_SELECT_I,
    input wire logic SOFTWARE_MODE_I,
    input wire logic DUAL_PULSE_MODE_I,
    input wire logic FALLING_EDGE_I,
    input wire logic [9:0] PROG_RESOLUTION_I,
    input wire logic [7:0] PROG_CURRENT_I,
    input wire logic OVER_CURRENT_I,
    input wire logic OVER_VOLTAGE_I,
    input wire logic PHASE_ERROR_I,
    output logic [9:0] RESOLUTION_O,
    output logic [7:0] DYNAMIC_CURRENT_O,
    output logic [7:0] CURRENT_COMMAND_O,
    output logic IDLE_REDUCED_O,
    output logic MOTOR_ENABLE_O,
    output logic [POS_W-1:0] POSITION_O,
    output logic [1:0] FAULT_CODE_O,
    output logic FAULT_LED_O
);

    // ----------------------------------------------------------------
    // Decode helpers
    // ----------------------------------------------------------------
    // Switch code is OFF-as-one; code 0 means programmed value
    function automatic logic [9:0] res_decode(input logic [3:0] code, input logic [9:0] prog);
        logic [9:0] r;
        r = prog;
        unique case (code)
            4'h0: r = prog;
            4'h1: r = 10'd2;
            4'h2: r = 10'd4;
            4'h3: r = 10'd8;
            4'h4: r = 10'd16;
            4'h5: r = 10'd32;
            4'h6: r = 10'd64;
            4'h7: r = 10'd128;
            4'h8: r = 10'd5;
            4'h9: r = 10'd10;
            4'hA: r = 10'd20;
            4'hB: r = 10'd25;
            4'hC: r = 10'd40;
            4'hD: r = 10'd50;
            4'hE: r = 10'd100;
            4'hF: r = 10'd125;
        endcase
        return r;
    endfunction

    // Current in tenths of an ampere; code 0 means programmed value
    function automatic logic [7:0] cur_decode(input logic [2:0] code, input logic [7:0] prog);
        logic [7:0] c;
        c = prog;
        unique case (code)
            3'd0: c = prog;
            3'd1: c = 8'd21;
            3'd2: c = 8'd27;
            3'd3: c = 8'd32;
            3'd4: c = 8'd38;
            3'd5: c = 8'd43;
            3'd6: c = 8'd49;
            3'd7: c = 8'd56;
        endcase
        return c;
    endfunction

    function automatic logic [7:0] pct_of(input logic [7:0] val, input logic [7:0] pct);
        logic [15:0] p;
        p = val * pct;
        return 8'((p / 16'd100));
    endfunction

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [2:0] step_sync;
        logic [2:0] dir_sync;
        logic [2:0] permit_sync;
        logic [2:0] oc_sync;
        logic [2:0] ov_sync;
        logic [2:0] ph_sync;
        logic step_lvl;
        logic dir_lvl;
        logic permit_lvl;
        logic [9:0] prog_res;
        logic [7:0] prog_cur;
        logic [9:0] resolution;
        logic [7:0] dyn_cur;
        logic [7:0] cur_cmd;
        logic [31:0] idle_cnt;
        logic idle;
        logic enable;
        logic [POS_W-1:0] pos;
        sdcf_pkg::sdcf_fault_t fault;
        sdcf_pkg::sdcf_led_t led_st;
        logic [31:0] frame_cnt;
        logic [31:0] flash_cnt;
        logic [2:0] flashes_left;
        logic led;
    } sdcf_state_t;

    sdcf_state_t cur, next_st;

    // Only the second and third stages are compared; the first never is
    function automatic logic filt(input logic [2:0] s, input logic held);
        return (s[1] == s[2]) ? s[2] : held;
    endfunction

    always_comb
    begin
        logic step_now;
        logic dir_now;
        logic step_edge;
        logic ccw_edge;
        logic accept;
        logic [9:0] res_req;
        logic [7:0] cur_req;
        logic [7:0] hold_pct;
        step_now = 1'b0;
        dir_now = 1'b0;
        step_edge = 1'b0;
        ccw_edge = 1'b0;
        accept = 1'b0;
        res_req = 10'd0;
        cur_req = 8'd0;
        hold_pct = 8'd0;
        next_st = cur;

        next_st.step_sync = {cur.step_sync[1:0], STEP_PULSE_INPUT_I};
        next_st.dir_sync = {cur.dir_sync[1:0], ROTATION_SENSE_I};
        next_st.permit_sync = {cur.permit_sync[1:0], DRIVE_PERMIT_INPUT_I};
        next_st.oc_sync = {cur.oc_sync[1:0], OVER_CURRENT_I};
        next_st.ov_sync = {cur.ov_sync[1:0], OVER_VOLTAGE_I};
        next_st.ph_sync = {cur.ph_sync[1:0], PHASE_ERROR_I};

        step_now = filt(cur.step_sync, cur.step_lvl);
        dir_now = filt(cur.dir_sync, cur.dir_lvl);
        next_st.step_lvl = step_now;
        next_st.dir_lvl = dir_now;
        // Pull-up on the pin makes an open input read as enabled
        next_st.permit_lvl = filt(cur.permit_sync, cur.permit_lvl);

        // ------------------------------------------------------------
        // Configuration
        // ------------------------------------------------------------
        if (PROG_RESOLUTION_I >= `SDCF_RES_MIN && PROG_RESOLUTION_I <= `SDCF_RES_MAX)
            next_st.prog_res = PROG_RESOLUTION_I;
        if (PROG_CURRENT_I >= `SDCF_CUR_MIN && PROG_CURRENT_I <= `SDCF_CUR_MAX)
            next_st.prog_cur = PROG_CURRENT_I;
        res_req = SOFTWARE_MODE_I ? cur.prog_res : res_decode(RESOLUTION_SELECT_I, cur.prog_res);
        cur_req = SOFTWARE_MODE_I ? cur.prog_cur : cur_decode(CURRENT_SELECT_I, cur.prog_cur);
        next_st.resolution = res_req;
        next_st.dyn_cur = cur_req;

        // ------------------------------------------------------------
        // Step acceptance
        // ------------------------------------------------------------
        // Outside dual-pulse mode, direction is taken from the filtered level, which the controller
        // keeps settled ahead of the edge
        step_edge = (cur.step_lvl ^ step_now) & (step_now ^ FALLING_EDGE_I);
        ccw_edge = (cur.dir_lvl ^ dir_now) & (dir_now ^ FALLING_EDGE_I);
        next_st.enable = cur.permit_lvl && (cur.fault == sdcf_pkg::SDCF_FLT_NONE);
        accept = cur.enable && (step_edge || (DUAL_PULSE_MODE_I && ccw_edge));
        if (accept && DUAL_PULSE_MODE_I)
            next_st.pos = step_edge ? cur.pos + 1'b1 : cur.pos - 1'b1;
        else if (accept)
            next_st.pos = cur.dir_lvl ? cur.pos + 1'b1 : cur.pos - 1'b1;

        // ------------------------------------------------------------
        // Idle reduction
        // ------------------------------------------------------------
        if (accept)
        begin
            next_st.idle_cnt = 32'd0;
            next_st.idle = 1'b0;
        end
        else if (cur.idle_cnt >= 32'(IDLE_CYCLES - 1))
        begin
            next_st.idle = 1'b1;
        end
        else
        begin
            next_st.idle_cnt = cur.idle_cnt + 32'd1;
        end
        // Idle target is the lower of sixty percent and the standstill level
        hold_pct = STANDSTILL_LEVEL_SELECT_I ? `SDCF_FULL_PCT : `SDCF_HALF_PCT;
        if (hold_pct > `SDCF_IDLE_PCT)
        begin
            hold_pct = `SDCF_IDLE_PCT;
        end
        if (!next_st.enable)
            next_st.cur_cmd = 8'd0;
        else if (next_st.idle)
            next_st.cur_cmd = pct_of(cur_req, hold_pct);
        else
            next_st.cur_cmd = cur_req;

        // ------------------------------------------------------------
        // Fault latch, never cleared except by reset
        // ------------------------------------------------------------
        if (cur.fault == sdcf_pkg::SDCF_FLT_NONE)
        begin
            if (cur.oc_sync[2] && cur.oc_sync[1])
                next_st.fault = sdcf_pkg::SDCF_FLT_OC;
            else if (cur.ov_sync[2] && cur.ov_sync[1])
                next_st.fault = sdcf_pkg::SDCF_FLT_OV;
            else if (cur.ph_sync[2] && cur.ph_sync[1])
                next_st.fault = sdcf_pkg::SDCF_FLT_PH;
        end
        else if (cur.oc_sync[2] && cur.oc_sync[1])
            next_st.fault = sdcf_pkg::SDCF_FLT_OC;
        else if (cur.ov_sync[2] && cur.ov_sync[1] && cur.fault == sdcf_pkg::SDCF_FLT_PH)
            next_st.fault = sdcf_pkg::SDCF_FLT_OV;

        // ------------------------------------------------------------
        // Indicator: flashes at frame start, then dark for the rest
        // ------------------------------------------------------------
        next_st.frame_cnt = (cur.frame_cnt >= 32'(FRAME_CYCLES - 1)) ? 32'd0
                                                                      : cur.frame_cnt + 32'd1;
        next_st.flash_cnt = (cur.flash_cnt >= 32'(FLASH_CYCLES - 1)) ? 32'd0
                                                                      : cur.flash_cnt + 32'd1;
        unique case (cur.led_st)
            sdcf_pkg::SDCF_LED_GAP:
            begin
                next_st.led = 1'b0;
                if (cur.frame_cnt == 32'd0 && cur.fault != sdcf_pkg::SDCF_FLT_NONE)
                begin
                    unique case (cur.fault)
                        sdcf_pkg::SDCF_FLT_OC: next_st.flashes_left = `SDCF_FLASH_OC;
                        sdcf_pkg::SDCF_FLT_OV: next_st.flashes_left = `SDCF_FLASH_OV;
                        default: next_st.flashes_left = `SDCF_FLASH_PH;
                    endcase
                    next_st.flash_cnt = 32'd0;
                    next_st.led = 1'b1;
                    next_st.led_st = sdcf_pkg::SDCF_LED_ON;
                end
            end
            sdcf_pkg::SDCF_LED_ON:
            begin
                if (cur.flash_cnt >= 32'(FLASH_CYCLES - 1))
                begin
                    next_st.led = 1'b0;
                    next_st.flashes_left = cur.flashes_left - 3'd1;
                    next_st.led_st = sdcf_pkg::SDCF_LED_OFF;
                end
            end
            sdcf_pkg::SDCF_LED_OFF:
            begin
                if (cur.flash_cnt >= 32'(FLASH_CYCLES - 1))
                begin
                    if (cur.flashes_left == 3'd0)
                    begin
                        next_st.led_st = sdcf_pkg::SDCF_LED_REST;
                    end
                    else
                    begin
                        next_st.led = 1'b1;
                        next_st.led_st = sdcf_pkg::SDCF_LED_ON;
                    end
                end
            end
            sdcf_pkg::SDCF_LED_REST:
            begin
                next_st.led_st = sdcf_pkg::SDCF_LED_GAP;
            end
        endcase
    end

    always_ff @(posedge REF_CLK_I)
    begin
        if (RST_I)
        begin
            cur <= '0;
            // Permit defaults to enabled, matching an open input
            cur.permit_sync <= 3'b111;
            cur.permit_lvl <= 1'b1;
            cur.prog_res <= `SDCF_RES_MAX;
            cur.prog_cur <= `SDCF_CUR_MAX;
        end
        else
        begin
            cur <= next_st;
        end
    end

    assign RESOLUTION_O = cur.resolution;
    assign DYNAMIC_CURRENT_O = cur.dyn_cur;
    assign CURRENT_COMMAND_O = cur.cur_cmd;
    assign IDLE_REDUCED_O = cur.idle;
    assign MOTOR_ENABLE_O = cur.enable;
    assign POSITION_O = cur.pos;
    assign FAULT_CODE_O = cur.fault;
    assign FAULT_LED_O = cur.led;

endmodule

// >>> test/sdcf_drive_asserts.sv
`timescale 1ns/10ps
module sdcf_drive_asserts #(
    parameter int unsigned POS_W = 32,
    parameter int unsigned IDLE_CYCLES = 200,
    parameter int unsigned FLASH_CYCLES = 20
) (
    input wire logic REF_CLK_I,
    input wire logic RST_I,
    input wire logic DRIVE_PERMIT_INPUT_I,
    input wire logic STANDSTILL_LEVEL_SELECT_I,
    input wire logic [7:0] DYNAMIC_CURRENT_O,
    input wire logic [7:0] CURRENT_COMMAND_O,
    input wire logic IDLE_REDUCED_O,
    input wire logic MOTOR_ENABLE_O,
    input wire logic [POS_W-1:0] POSITION_O,
    input wire logic [1:0] FAULT_CODE_O,
    input wire logic FAULT_LED_O
);
    // ----
    // Helper counters
    // ----
    int quiet;
    int lit;
    logic [POS_W-1:0] last_pos;
    logic [15:0] idle_cmd;
    // Idle level is the lower of sixty percent and the standstill setting
    assign idle_cmd = 16'(DYNAMIC_CURRENT_O) * (STANDSTILL_LEVEL_SELECT_I ? 16'h003C : 16'h0032)
        / 16'h0064;
    always_ff @(posedge REF_CLK_I)
    begin
        last_pos <= POSITION_O;
        quiet <= (RST_I || POSITION_O != last_pos) ? 0 : quiet + 1;
        lit <= FAULT_LED_O ? lit + 1 : 0;
    end
    default clocking cb @(posedge REF_CLK_I); endclocking
    default disable iff (RST_I);
    AST_FAULT_OFF: assert property (FAULT_CODE_O != 2'h0 |=> !MOTOR_ENABLE_O)
        else $error("motor enabled with a fault latched");
    AST_FAULT_HOLD: assert property (FAULT_CODE_O != 2'h0 |=>
        FAULT_CODE_O != 2'h0 && FAULT_CODE_O <= $past(FAULT_CODE_O))
        else $error("latched fault cleared or lowered");
    AST_OFF_CMD: assert property (!MOTOR_ENABLE_O && $past(!MOTOR_ENABLE_O) |->
        CURRENT_COMMAND_O == 8'h00) else $error("command while disabled");
    AST_PERMIT: assert property (!DRIVE_PERMIT_INPUT_I [*6] |-> !MOTOR_ENABLE_O)
        else $error("enabled without permit");
    AST_POS_STEP: assert property ($changed(POSITION_O) |->
        POSITION_O - $past(POSITION_O) inside {1, {POS_W{1'b1}}})
        else $error("position moved by more than one");
    AST_POS_HOLD: assert property (!MOTOR_ENABLE_O [*3] |=> $stable(POSITION_O))
        else $error("position moved while disabled");
    AST_IDLE_RISE: assert property ($rose(IDLE_REDUCED_O) |->
        quiet >= IDLE_CYCLES - 3 && quiet <= IDLE_CYCLES + 3)
        else $error("idle reduction at wrong time");
    AST_IDLE_CMD: assert property (IDLE_REDUCED_O && MOTOR_ENABLE_O
        && $past(MOTOR_ENABLE_O) && $past(IDLE_REDUCED_O) && $stable(DYNAMIC_CURRENT_O)
        |-> CURRENT_COMMAND_O == idle_cmd[7:0]) else $error("wrong idle command");
    AST_RUN_CMD: assert property (!IDLE_REDUCED_O && !$past(IDLE_REDUCED_O)
        && MOTOR_ENABLE_O && $past(MOTOR_ENABLE_O) && $stable(DYNAMIC_CURRENT_O)
        |-> CURRENT_COMMAND_O == DYNAMIC_CURRENT_O) else $error("wrong running command");
    AST_STEP_WAKE: assert property ($changed(POSITION_O) |=> !IDLE_REDUCED_O)
        else $error("step did not end idle reduction");
    AST_LED_DARK: assert property (FAULT_CODE_O == 2'h0 |-> !FAULT_LED_O)
        else $error("indicator lit without fault");
    AST_LED_LEN: assert property ($fell(FAULT_LED_O) |-> lit == FLASH_CYCLES)
        else $error("flash length wrong");
endmodule

bind sdcf_drive sdcf_drive_asserts #(
    .POS_W(POS_W),
    .IDLE_CYCLES(IDLE_CYCLES),
    .FLASH_CYCLES(FLASH_CYCLES)
) sdcf_drive_asserts_inst (
    .REF_CLK_I(REF_CLK_I), .RST_I(RST_I), .DRIVE_PERMIT_INPUT_I(DRIVE_PERMIT_INPUT_I),
    .STANDSTILL_LEVEL_SELECT_I(STANDSTILL_LEVEL_SELECT_I),
    .DYNAMIC_CURRENT_O(DYNAMIC_CURRENT_O), .CURRENT_COMMAND_O(CURRENT_COMMAND_O),
    .IDLE_REDUCED_O(IDLE_REDUCED_O), .MOTOR_ENABLE_O(MOTOR_ENABLE_O),
    .POSITION_O(POSITION_O), .FAULT_CODE_O(FAULT_CODE_O), .FAULT_LED_O(FAULT_LED_O)
);

// >>> test/sdcf_pulse_gen.sv
`timescale 1ns/10ps
module sdcf_pulse_gen #(
    parameter int SETUP = 625,
    parameter int WIDTH = 313
) (
    input wire logic clk_i,
    input wire logic req_i,
    input wire logic dir_i,
    input wire logic dual_i,
    input wire logic inv_i,
    output logic step_o,
    output logic sense_o,
    output logic ack_o
);
    // ----
    // Behavioural step source
    // ----
    logic act = 1'b0;
    logic dir = 1'b0;
    initial ack_o = 1'b0;
    // Inverted idle level makes the falling edge the active one
    assign step_o = inv_i ^ (act && (dir || !dual_i));
    assign sense_o = dual_i ? inv_i ^ (act && !dir) : dir;
    always @(posedge clk_i)
    begin
        if (req_i && !ack_o)
        begin
            dir <= dir_i;
            repeat (SETUP) @(posedge clk_i);
            act <= 1'b1;
            repeat (WIDTH) @(posedge clk_i);
            act <= 1'b0;
            repeat (WIDTH) @(posedge clk_i);
            ack_o <= 1'b1;
            @(posedge clk_i);
            ack_o <= 1'b0;
        end
    end
endmodule

// >>> test/sdcf_drive_tb_top.sv
`timescale 1ns/10ps
module sdcf_drive_tb_top;
    // ----
    // Bench
    // ----
    localparam int IDLE = 2000;
    localparam int FRAME = 400;
    localparam int FLASH = 20;
    logic clk, rst, step, sense, permit, ss_sel, sw_mode, dual, fall, oc, ov, ph;
    logic req, dir, ack, idle, en, led;
    logic [2:0] cur_sel;
    logic [3:0] res_sel;
    logic [9:0] prog_res, res;
    logic [7:0] prog_cur, dyn, cmd;
    logic [31:0] pos;
    logic [1:0] fcode;
    int err_count, cmp_count, exp_pos, n;
    logic [9:0] res_lut [16] = '{10'h0C8, 10'h002, 10'h004, 10'h008, 10'h010, 10'h020,
        10'h040, 10'h080, 10'h005, 10'h00A, 10'h014, 10'h019, 10'h028, 10'h032, 10'h064, 10'h07D};
    logic [7:0] cur_lut [8] = '{8'h05, 8'h15, 8'h1B, 8'h20, 8'h26, 8'h2B, 8'h31, 8'h38};
    logic [17:0] prog_in [3] = '{18'h0_0138, 18'h2_0104, 18'h2_0005};
    logic [17:0] prog_exp [3] = '{18'h0_0138, 18'h0_0138, 18'h2_0005};

    sdcf_drive #(.IDLE_CYCLES(IDLE), .FRAME_CYCLES(FRAME), .FLASH_CYCLES(FLASH)) sdcf_drive_inst (
        .REF_CLK_I(clk), .RST_I(rst), .STEP_PULSE_INPUT_I(step), .ROTATION_SENSE_I(sense),
        .DRIVE_PERMIT_INPUT_I(permit), .CURRENT_SELECT_I(cur_sel),
        .STANDSTILL_LEVEL_SELECT_I(ss_sel), .RESOLUTION_SELECT_I(res_sel),
        .SOFTWARE_MODE_I(sw_mode), .DUAL_PULSE_MODE_I(dual), .FALLING_EDGE_I(fall),
        .PROG_RESOLUTION_I(prog_res), .PROG_CURRENT_I(prog_cur), .OVER_CURRENT_I(oc),
        .OVER_VOLTAGE_I(ov), .PHASE_ERROR_I(ph), .RESOLUTION_O(res), .DYNAMIC_CURRENT_O(dyn),
        .CURRENT_COMMAND_O(cmd), .IDLE_REDUCED_O(idle), .MOTOR_ENABLE_O(en),
        .POSITION_O(pos), .FAULT_CODE_O(fcode), .FAULT_LED_O(led));
    sdcf_pulse_gen sdcf_pulse_gen_inst (.clk_i(clk), .req_i(req), .dir_i(dir), .dual_i(dual),
        .inv_i(fall), .step_o(step), .sense_o(sense), .ack_o(ack));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            err_count++;
            $display("unexpected at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic pulse(input logic d, input logic ok);
        req <= 1'b1;
        dir <= d;
        for (int t = 0; t < 2000 && ack !== 1'b1; t++)
            @(posedge clk);
        check(ack, 1'b1);
        req <= 1'b0;
        repeat (8) @(posedge clk);
        if (ok)
            exp_pos += d ? 1 : -1;
        check(pos, 32'(exp_pos));
    endtask

    // Two whole frames hold the same number of flashes wherever the count starts
    task automatic flashes(output int cnt);
        logic p;
        repeat (FRAME) @(posedge clk);
        p = led;
        cnt = 0;
        repeat (2 * FRAME)
        begin
            @(posedge clk);
            cnt += int'(led === 1'b1 && p === 1'b0);
            p = led;
        end
    endtask

    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    initial
    begin
        repeat (100000) @(posedge clk);
        err_count++;
        complete_run();
    end

    initial
    begin
        {rst, permit} = 2'h3;
        {req, dir, ss_sel, sw_mode, dual, fall, oc, ov, ph} = 9'h000;
        cur_sel = 3'h0;
        res_sel = 4'h0;
        prog_res = 10'h0C8;
        prog_cur = 8'h05;
        err_count = 0;
        cmp_count = 0;
        exp_pos = 0;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        repeat (4) @(posedge clk);
        check(en, 1'b1);
        $display("reset test done");
        for (int c = 0; c < 16; c++)
        begin
            res_sel <= 4'(c);
            repeat (4) @(posedge clk);
            check(res, res_lut[c]);
        end
        for (int c = 0; c < 8; c++)
        begin
            cur_sel <= 3'(c);
            repeat (4) @(posedge clk);
            check(dyn, cur_lut[c]);
        end
        sw_mode <= 1'b1;
        for (int i = 0; i < 3; i++)
        begin
            {prog_res, prog_cur} <= prog_in[i];
            repeat (4) @(posedge clk);
            check({res, dyn}, prog_exp[i]);
        end
        {sw_mode, res_sel, cur_sel} <= 8'h23;
        $display("setting test done");
        for (int m = 0; m < 4; m++)
        begin
            permit <= 1'b0;
            {fall, dual} <= 2'(m);
            repeat (8) @(posedge clk);
            pulse(1'b1, 1'b0);
            permit <= 1'b1;
            repeat (625) @(posedge clk);
            pulse(1'b0, 1'b1);
            pulse(1'b0, 1'b1);
            pulse(1'b1, 1'b1);
        end
        $display("step test done");
        pulse(1'b1, 1'b1);
        check(cmd, 8'h20);
        repeat (IDLE) @(posedge clk);
        check(idle, 1'b1);
        check(cmd, 8'h10);
        pulse(1'b1, 1'b1);
        ss_sel <= 1'b1;
        check(idle, 1'b0);
        check(cmd, 8'h20);
        repeat (IDLE) @(posedge clk);
        check(cmd, 8'h13);
        $display("idle test done");
        for (int i = 0; i < 3; i++)
        begin
            {oc, ov, ph} <= 3'h1 << i;
            repeat (8) @(posedge clk);
            check(fcode, 32'(3 - i));
            check(cmd, 8'h00);
            flashes(n);
            check(n, 32'(2 << (2 - i)));
        end
        {oc, ov, ph} <= 3'h0;
        pulse(1'b1, 1'b0);
        check(fcode, sdcf_pkg::SDCF_FLT_OC);
        {rst, ov, ph} <= 3'h7;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        repeat (8) @(posedge clk);
        check(fcode, sdcf_pkg::SDCF_FLT_OV);
        $display("fault test done");
        complete_run();
    end
endmodule
